//--- rtl/sbc_pkg.sv
// shared constants and types for the strap and serial bus config block
package sbc_pkg;

    // serial bus configuration strap encodings
    localparam logic [1:0] BUS_I2C_EEPROM = 2'h0;
    localparam logic [1:0] BUS_RESERVED   = 2'h1;
    localparam logic [1:0] BUS_SPI_SLAVE  = 2'h2;
    localparam logic [1:0] BUS_BIST       = 2'h3;

    // frame size limits; the receive-error strap selects only the tagged and large ones
    localparam logic [10:0] FRAME_MAX_TAGGED = 11'h5f2;
    localparam logic [10:0] FRAME_MAX_PLAIN  = 11'h5ee;
    localparam logic [10:0] FRAME_MAX_LARGE  = 11'h600;

    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    // register byte offsets
    localparam logic [7:0] REG_STRAP  = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CTRL   = 8'h08;

    // field positions in the strap register
    localparam int STRAP_BUS_LSB  = 0;
    localparam int STRAP_RXER_BIT = 2;
    localparam int STRAP_FLSB     = 16;
    // field positions in the status register
    localparam int ST_LOADED_BIT  = 0;
    localparam int ST_DEFAULT_BIT = 1;
    localparam int ST_PDN_BIT     = 2;
    localparam int ST_STATE_LSB   = 4;
    // control register: bit 0 = eeprom present, bit 1 = load request
    localparam int CTRL_EEP_BIT   = 0;
    localparam int CTRL_LOAD_BIT  = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // strap pin count: rx error pin plus two bus cfg bits
    localparam int NUM_STRAPS = 3;

    typedef enum logic [1:0] {
        SBC_I2C,
        SBC_RSVD,
        SBC_SPI,
        SBC_BIST
    } sbc_bus_mode_t;

    typedef struct packed {
        logic [1:0]  serial_bus_cfg;
        logic        large_frames;
        logic [10:0] frame_max;
    } sbc_strap_t;

    typedef struct packed {
        logic [NUM_STRAPS-1:0] o;
        logic [NUM_STRAPS-1:0] oe;
        logic [NUM_STRAPS-1:0] pull_up;
        logic [NUM_STRAPS-1:0] pull_down;
    } sbc_pad_t;

endpackage

//--- rtl/sbc_strap_pad.sv
// one dual-use strap pad: pulled input in reset, output afterwards
module sbc_strap_pad #(
    parameter bit PULL_UP = 1'b0
) (
    // reset state
    input  wire logic in_reset,
    // core side
    input  wire logic core_o,
    // pad controls
    output logic      pad_o,
    output logic      pad_oe,
    output logic      pad_pu,
    output logic      pad_pd
);
    always_comb
    begin
        pad_o  = core_o & ~in_reset;
        pad_oe = ~in_reset;              // [RULE_01] [RULE_02]
        pad_pu = in_reset & PULL_UP;     // [RULE_02]
        pad_pd = in_reset & ~PULL_UP;    // [RULE_01]
    end
endmodule

//--- rtl/sbc_top.sv
// strap capture, serial bus mode select and config register slave
// Contract
// RULE_01: pull-down strap pins are pulled-down inputs in reset, outputs after; the bus cfg pins stay pulled-down inputs after reset.
// RULE_02: pull-up strap pins are pulled-up inputs in reset, outputs after.
// RULE_03: receive-error strap low gives 1522/1518 byte limit, high 1536. Here low always gives 1522 (FRAME_MAX_TAGGED); 1518 is never selected.
// RULE_04: bus cfg 00 i2c eeprom, 01 reserved, 10 spi slave, 11 bist.
// RULE_05: with no eeprom present the device uses built-in default config.
// RULE_06: power-down input low powers the whole device down; pulled up. Here it only drives powered_down and the status bit.
// RULE_07: reset input low resets the whole device; pulled up.
// RULE_08: straps latch at reset release and hold until the next reset.
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
module sbc_top (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // strap pins: receive error, bus cfg bit 0, bus cfg bit 1
    input  wire logic        port5_rx_error_pin,
    input  wire logic        serial_bus_cfg_bit0,
    input  wire logic        serial_bus_cfg_bit1,
    output sbc_pkg::sbc_pad_t strap_pad,
    // core data driven on the receive-error pin after reset
    input  wire logic        port5_rx_error_out,
    // power down
    input  wire logic        chip_powerdown_n,
    output logic             chip_powerdown_pad_pu,
    output logic             chip_reset_pad_pu,
    output logic             powered_down,
    // decoded configuration
    output sbc_pkg::sbc_strap_t cfg,
    output sbc_pkg::sbc_bus_mode_t bus_mode,
    output logic             use_default_cfg,
    output logic             cfg_ready
);
    typedef enum logic [1:0] {
        ST_CAPTURE,
        ST_DECIDE,
        ST_LOAD,
        ST_RUN
    } sbc_state_t;

    sbc_state_t         state_q, state_d;
    logic               in_reset_q;
    sbc_pkg::sbc_strap_t cfg_q, cfg_d;
    logic               dflt_q, dflt_d;
    logic               loaded_q, loaded_d;
    logic [31:0]        ctrl_q, ctrl_d;
    logic               ap_valid_q, ap_valid_d;
    logic               ap_write_q, ap_write_d;
    logic [7:0]         ap_addr_q, ap_addr_d;
    logic [31:0]        rdata_q, rdata_d;
    logic [31:0]        rd_mux;
    logic               load_req;
    logic               rxer_o;
    logic               rxer_oe;
    logic               rxer_pu;
    logic               rxer_pd;

    // the pin-side reset is hresetn itself; in_reset_q marks the first
    // cycle after release so capture happens exactly at that edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            in_reset_q <= 1'b1;
        else
            in_reset_q <= 1'b0;
    end

    // pads: rx error is a pull-down strap; bus cfg pins are plain inputs
    // so they keep their pull-down and never turn to outputs
    sbc_strap_pad #(
        .PULL_UP (1'b0)
    ) u_rxer_pad (
        .in_reset (in_reset_q),
        .core_o   (port5_rx_error_out),
        .pad_o    (rxer_o),
        .pad_oe   (rxer_oe),
        .pad_pu   (rxer_pu),
        .pad_pd   (rxer_pd)
    );

    // the pad struct has a single driver; the pad cell feeds index 0
    always_comb
    begin
        strap_pad.o              = {2'h0, rxer_o};       // [RULE_01]
        strap_pad.oe             = {2'h0, rxer_oe};      // [RULE_01]
        strap_pad.pull_up        = {2'h0, rxer_pu};
        strap_pad.pull_down      = {2'h3, rxer_pd};      // [RULE_01]
        chip_powerdown_pad_pu    = 1'b1;   // [RULE_06]
        chip_reset_pad_pu        = 1'b1;   // [RULE_07]
    end

    // ---- strap capture and config sequencing ----
    assign load_req = ctrl_q[sbc_pkg::CTRL_LOAD_BIT];

    always_comb
    begin
        state_d  = state_q;
        cfg_d    = cfg_q;
        dflt_d   = dflt_q;
        loaded_d = loaded_q;
        unique case (state_q)
            ST_CAPTURE:
            begin
                // straps sampled once, at the first edge after release
                cfg_d.serial_bus_cfg = {serial_bus_cfg_bit1,
                                        serial_bus_cfg_bit0}; // [RULE_08]
                cfg_d.large_frames   = port5_rx_error_pin;    // [RULE_08]
                cfg_d.frame_max      = port5_rx_error_pin
                                     ? sbc_pkg::FRAME_MAX_LARGE
                                     : sbc_pkg::FRAME_MAX_TAGGED; // [RULE_03]
                state_d = ST_DECIDE;
            end
            ST_DECIDE:
            begin
                // only i2c mode fetches from eeprom; absent eeprom
                // falls back to the built-in defaults. ctrl_d lets a
                // presence write landing in this very cycle be heard
                if (cfg_q.serial_bus_cfg == sbc_pkg::BUS_I2C_EEPROM &&
                    ctrl_d[sbc_pkg::CTRL_EEP_BIT])
                begin
                    state_d = ST_LOAD;
                end
                else
                begin
                    dflt_d  = 1'b1;                      // [RULE_05]
                    state_d = ST_RUN;
                end
            end
            ST_LOAD:
            begin
                if (load_req)
                begin
                    loaded_d = 1'b1;
                    state_d  = ST_RUN;
                end
            end
            ST_RUN:
            begin
                state_d = ST_RUN;                        // [RULE_08]
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q  <= ST_CAPTURE;                      // [RULE_07]
            cfg_q    <= '0;
            dflt_q   <= 1'b0;
            loaded_q <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            cfg_q    <= cfg_d;
            dflt_q   <= dflt_d;
            loaded_q <= loaded_d;
        end
    end

    always_comb
    begin
        unique case (cfg_q.serial_bus_cfg)                // [RULE_04]
            sbc_pkg::BUS_I2C_EEPROM: bus_mode = sbc_pkg::SBC_I2C;
            sbc_pkg::BUS_RESERVED:   bus_mode = sbc_pkg::SBC_RSVD;
            sbc_pkg::BUS_SPI_SLAVE:  bus_mode = sbc_pkg::SBC_SPI;
            sbc_pkg::BUS_BIST:       bus_mode = sbc_pkg::SBC_BIST;
        endcase
        cfg             = cfg_q;
        use_default_cfg = dflt_q;
        cfg_ready       = (state_q == ST_RUN);
        powered_down    = ~chip_powerdown_n;             // [RULE_06]
    end

    // ---- ahb-lite slave, zero wait states ----
    // only whole-word transfers are decoded; narrower ones are ignored
    // rather than merged, since every register is a single word
    always_comb
    begin
        ap_valid_d = hsel && hready
                  && (htrans == sbc_pkg::HTRANS_NONSEQ)
                  && (hsize == sbc_pkg::HSIZE_WORD);
        ap_write_d = hwrite;
        ap_addr_d  = haddr[7:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_addr_q  <= 8'h00;
        end
        else
        begin
            ap_valid_q <= ap_valid_d;
            ap_write_q <= ap_write_d;
            ap_addr_q  <= ap_addr_d;
        end
    end

    // load request is a one-shot cleared once consumed; the clear comes
    // first so a software write in the same cycle wins
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (state_q == ST_LOAD && load_req)
            ctrl_d[sbc_pkg::CTRL_LOAD_BIT] = 1'b0;
        if (ap_valid_q && ap_write_q && ap_addr_q == sbc_pkg::REG_CTRL)
            ctrl_d = hwdata;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_q <= sbc_pkg::CTRL_RESET;
        else
            ctrl_q <= ctrl_d;
    end

    // read word is picked in the address phase, stands in the data phase
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            sbc_pkg::REG_STRAP:
            begin
                rd_mux[sbc_pkg::STRAP_BUS_LSB +: 2] = cfg_q.serial_bus_cfg;
                rd_mux[sbc_pkg::STRAP_RXER_BIT]     = cfg_q.large_frames;
                rd_mux[sbc_pkg::STRAP_FLSB +: 11]   = cfg_q.frame_max;
            end
            sbc_pkg::REG_STATUS:
            begin
                rd_mux[sbc_pkg::ST_LOADED_BIT]    = loaded_q;
                rd_mux[sbc_pkg::ST_DEFAULT_BIT]   = dflt_q;
                rd_mux[sbc_pkg::ST_PDN_BIT]       = ~chip_powerdown_n;
                rd_mux[sbc_pkg::ST_STATE_LSB +: 2] = state_q;
            end
            sbc_pkg::REG_CTRL:
                rd_mux = ctrl_q;
            default:
                rd_mux = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        rdata_d = rdata_q;
        if (ap_valid_d && !hwrite)
            rdata_d = rd_mux;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_q <= 32'h0000_0000;
        else
            rdata_q <= rdata_d;
    end

    always_comb
    begin
        hrdata    = rdata_q;
        hreadyout = 1'b1;
        hresp     = 1'b0;
    end
endmodule

//--- tb/sbc_top_assertions.sv
// concurrent checks on the strap and serial bus config ports
module sbc_top_assertions (
    // clock and reset
    input wire logic                   hclk,
    input wire logic                   hresetn,
    // strap side
    input wire logic                   port5_rx_error_pin,
    input wire logic                   serial_bus_cfg_bit0,
    input wire logic                   serial_bus_cfg_bit1,
    input wire logic                   port5_rx_error_out,
    input wire sbc_pkg::sbc_pad_t      strap_pad,
    // power and status
    input wire logic                   chip_powerdown_n,
    input wire logic                   chip_powerdown_pad_pu,
    input wire logic                   chip_reset_pad_pu,
    input wire logic                   powered_down,
    input wire sbc_pkg::sbc_strap_t    cfg,
    input wire sbc_pkg::sbc_bus_mode_t bus_mode,
    input wire logic                   use_default_cfg,
    input wire logic                   cfg_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_PAD_IN: assert property (
        $rose(hresetn) |-> strap_pad.oe == 3'h0
        && strap_pad.pull_down == 3'h7) else $error("pads not pulled inputs");
    AST_PAD_OUT: assert property (cfg_ready |-> strap_pad.oe[0]
        && !strap_pad.pull_down[0] && strap_pad.o[0] == port5_rx_error_out)
        else $error("rx error pad not driving");
    AST_PULLUP: assert property (
        chip_powerdown_pad_pu && chip_reset_pad_pu
        && strap_pad.pull_up == 3'h0) else $error("pull-up state wrong");
    AST_PDN: assert property (powered_down == !chip_powerdown_n)
        else $error("power-down not following input");
    AST_FRAME: assert property (cfg_ready |-> cfg.frame_max ==
        (cfg.large_frames ? sbc_pkg::FRAME_MAX_LARGE
                          : sbc_pkg::FRAME_MAX_TAGGED))
        else $error("frame limit wrong");
    AST_MODE: assert property (bus_mode ==
        sbc_pkg::sbc_bus_mode_t'(cfg.serial_bus_cfg)) else $error("bad mode");
    AST_CAPTURE: assert property ($rose(hresetn) |-> ##2
        cfg.large_frames == $past(port5_rx_error_pin, 2)
        && cfg.serial_bus_cfg[0] == $past(serial_bus_cfg_bit0, 2)
        && cfg.serial_bus_cfg[1] == $past(serial_bus_cfg_bit1, 2))
        else $error("straps not latched at release");
    AST_HOLD: assert property (
        cfg_ready && $past(cfg_ready) |-> $stable(cfg))
        else $error("latched straps changed");
    AST_DEFAULT: assert property (cfg_ready && !use_default_cfg
        |-> cfg.serial_bus_cfg == sbc_pkg::BUS_I2C_EEPROM)
        else $error("loaded config outside eeprom mode");
    AST_DEFAULT_SET: assert property (
        cfg_ready && cfg.serial_bus_cfg != sbc_pkg::BUS_I2C_EEPROM
        |-> use_default_cfg) else $error("default config not taken");
endmodule

bind sbc_top sbc_top_assertions u_sbc_top_assertions (
    .hclk(hclk), .hresetn(hresetn), .port5_rx_error_pin(port5_rx_error_pin),
    .serial_bus_cfg_bit0(serial_bus_cfg_bit0), .strap_pad(strap_pad),
    .serial_bus_cfg_bit1(serial_bus_cfg_bit1), .cfg(cfg),
    .port5_rx_error_out(port5_rx_error_out), .bus_mode(bus_mode),
    .chip_powerdown_n(chip_powerdown_n), .powered_down(powered_down),
    .chip_powerdown_pad_pu(chip_powerdown_pad_pu), .cfg_ready(cfg_ready),
    .chip_reset_pad_pu(chip_reset_pad_pu), .use_default_cfg(use_default_cfg));

//--- tb/sbc_board.sv
// board model: strap resistors and wire level of the dual-use pads
module sbc_board (
    // clock
    input wire logic              hclk,
    // pad controls from the device
    input wire sbc_pkg::sbc_pad_t pad,
    // board resistors: fitted flag and level
    input wire logic              fitted,
    input wire logic [2:0]        strap_v,
    // resolved pin levels
    output logic [2:0]            pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog_q = 1'b0;
    // an undriven unpulled line wanders instead of holding a value
    always @(posedge hclk) tog_q <= ~tog_q;
    always_comb
    begin
        for (int i = 0; i < 3; i++)
            pin[i] = pad.oe[i] ? pad.o[i] : fitted ? strap_v[i] :
                     pad.pull_up[i] ? 1'b1 :
                     pad.pull_down[i] ? 1'b0 :
                     tog_q;
    end
endmodule

//--- tb/tb.sv
// testbench: strap capture over eight strap codes plus register access
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 0, hresetn = 0, hwrite = 0, out_q = 0, pdn_n = 1;
    logic fit_q = 0, rd_p = 0, hreadyout, hresp, pd, ppu, rpu, udef, rdy;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0]  htrans = 0;
    logic [2:0]  strap_v = 0, pin;
    logic [15:0] lfsr = 16'h98ae;
    logic [31:0] q[$];
    int failures = 0, n_tests = 0, cyc = 0;
    sbc_pkg::sbc_pad_t pad;
    sbc_pkg::sbc_strap_t cfg;
    sbc_pkg::sbc_bus_mode_t mode;

    always #2 hclk = ~hclk;

    sbc_board u_sbc_board (.hclk(hclk), .pad(pad), .fitted(fit_q),
        .strap_v(strap_v), .pin(pin));
    sbc_top u_sbc_top (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(sbc_pkg::HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .port5_rx_error_pin(pin[0]), .serial_bus_cfg_bit0(pin[1]),
        .serial_bus_cfg_bit1(pin[2]), .strap_pad(pad),
        .port5_rx_error_out(out_q), .chip_powerdown_n(pdn_n),
        .chip_powerdown_pad_pu(ppu), .chip_reset_pad_pu(rpu),
        .powered_down(pd), .cfg(cfg), .bus_mode(mode),
        .use_default_cfg(udef), .cfg_ready(rdy));

    function automatic logic [15:0] nxt(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [13:0] exp_cfg(logic [2:0] s);
        return {s[2:1], s[0], s[0] ? sbc_pkg::FRAME_MAX_LARGE
                                   : sbc_pkg::FRAME_MAX_TAGGED};
    endfunction

    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        if (failures == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // a read notes its expected word; the monitor checks it in data phase
    task automatic ahb(logic wr, logic [7:0] a, logic [31:0] d);
        if (!wr)
            q.push_back(d);
        @(posedge hclk);
        htrans <= sbc_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    always @(posedge hclk)
    begin
        cyc++;
        if (cyc > 4000)
        begin
            failures++;
            give_verdict();
        end
        if (rd_p)
            chk(hrdata, q.pop_front());
        rd_p <= htrans == sbc_pkg::HTRANS_NONSEQ && !hwrite && hreadyout;
    end

    initial
    begin
        for (int i = 0; i < 8; i++)
        begin
            logic [13:0] e;
            // code 0 has no board resistor, so the internal pull decides
            e = exp_cfg(i[2:0]);
            @(posedge hclk);
            hresetn <= 0;
            strap_v <= i[2:0];
            fit_q <= i != 0;
            lfsr = nxt(lfsr);
            out_q <= lfsr[0];
            repeat (3) @(posedge hclk);
            chk(pad.oe, 0);
            chk(pad.pull_down, 3'h7);
            chk({ppu, rpu, pad.pull_up}, 5'h18);
            chk({cfg, rdy}, 0);
            hresetn <= 1;
            repeat (4) @(posedge hclk);
            strap_v <= lfsr[3:1];
            repeat (2) @(posedge hclk);
            chk(cfg, e);
            chk(mode, i[2:1]);
            chk({udef, rdy}, 2'h3);
            chk({pad.oe[0], pad.pull_down[0]}, 2'h2);
            chk(pad.o[0], out_q);
            ahb(0, sbc_pkg::REG_STRAP, {5'h0, e[10:0], 13'h0, e[11],
                e[13:12]});
        end
        ahb(1, sbc_pkg::REG_STRAP, 32'hffff_ffff);
        ahb(0, sbc_pkg::REG_STRAP, 32'h0600_0007);
        ahb(1, sbc_pkg::REG_CTRL, 32'h0000_0001);
        ahb(0, sbc_pkg::REG_CTRL, 32'h0000_0001);
        ahb(0, 8'h0c, 32'h0);
        pdn_n <= 0;
        @(posedge hclk);
        @(negedge hclk) chk(pd, 1);
        ahb(0, sbc_pkg::REG_STATUS, 32'h0000_0036);
        @(posedge hclk) pdn_n <= 1;
        @(negedge hclk) chk(pd, 0);
        // eeprom declared by a write whose data phase is the decide cycle
        @(posedge hclk);
        hresetn <= 0;
        strap_v <= 3'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1;
        htrans <= sbc_pkg::HTRANS_NONSEQ;
        hwrite <= 1;
        haddr <= {24'h0, sbc_pkg::REG_CTRL};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= 32'h0000_0001;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        chk(rdy, 0);
        ahb(1, sbc_pkg::REG_CTRL, 32'h0000_0003);
        ahb(0, sbc_pkg::REG_CTRL, 32'h0000_0001);
        ahb(0, sbc_pkg::REG_STATUS, 32'h0000_0031);
        chk({udef, rdy}, 2'h1);
        repeat (2) @(posedge hclk);
        give_verdict();
    end
endmodule
